// *** logic/asr_scan_rate_irq_regs.sv ***
// scan code, sample rate, interrupt level and vector registers
// assumes synchronous 16-bit register port with byte strobes
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module asr_scan_rate_irq_regs
    import asr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        regSel,
    input  wire logic        regWr,
    input  wire logic [7:0]  regAddr,
    input  wire logic [1:0]  regByteEn,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    input  wire logic        softReset,
    input  wire logic        intAckCycle,
    output logic      [7:0]  ackData,
    output logic             ackDataOe,
    input  wire logic        irqPending,
    output logic      [2:0]  irqLevel,
    output logic             irqEnabled,
    output logic             scanValid,
    output logic             scanBig,
    output logic      [2:0]  scanBlock,
    output logic      [5:0]  scanFirst,
    output logic      [4:0]  scanTag,
    output logic             sampleTick
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [15:0] chan_r, chan_nxt;
    logic [14:0] rate_r, rate_nxt;
    logic [2:0]  lvl_r, lvl_nxt;
    logic [7:0]  vec_r, vec_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic [7:0]  ack_r, ack_nxt;
    logic        ackOe_r, ackOe_nxt;
    asr_scan_t   scan;
    asr_rate_if  rif ();
    logic [15:0] rateMerged;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic asr_scan_t decode(input logic [15:0] w);
        asr_scan_t s;
        s.valid = 1'b1;
        s.big   = 1'b0;
        s.block = ASR_BLKNONE;
        s.first = 6'h00;
        unique case (w[15:11])
            5'b10110: begin
                s.block = ASR_BLK1;
                s.first = w[5:0];
            end
            5'b11011: begin
                s.big   = 1'b1;
                s.block = ASR_BLK1;
                s.first = w[5:0];
            end
            5'b10111: begin
                s.block = ASR_BLK8;
                s.first = {w[2:0], 3'h0};
            end
            5'b11100: begin
                s.big   = 1'b1;
                s.block = ASR_BLK8;
                s.first = {w[2:0], 3'h0};
            end
            5'b11000: begin
                s.block = ASR_BLK16;
                s.first = {w[2:1], 4'h0};
            end
            5'b11101: begin
                s.big   = 1'b1;
                s.block = ASR_BLK16;
                s.first = {w[2:1], 4'h0};
            end
            5'b11001: begin
                s.block = ASR_BLK32;
                s.first = {w[2], 5'h00};
            end
            5'b11110: begin
                s.big   = 1'b1;
                s.block = ASR_BLK32;
                s.first = {w[2], 5'h00};
            end
            5'b11010: s.block = ASR_BLK64;
            5'b11111: begin
                s.big   = 1'b1;
                s.block = ASR_BLK64;
            end
            default:  s.valid = 1'b0;
        endcase
        return s;
    endfunction

    // ----------------------------------------
    // write, read and acknowledge
    // ----------------------------------------
    always_comb begin
        chan_nxt  = chan_r;
        rate_nxt  = rate_r;
        lvl_nxt   = lvl_r;   // software reset leaves level alone
        vec_nxt   = vec_r;   // software reset leaves vector alone
        rd_nxt    = rd_r;
        rateMerged = merge({1'b0, rate_r}, regWdata, regByteEn);
        if (regSel && regWr) begin
            unique case (regAddr)
                `ASR_OFS_CHAN: chan_nxt = merge(chan_r, regWdata, regByteEn);
                `ASR_OFS_RATE: rate_nxt = rateMerged[14:0];
                `ASR_OFS_IRQ_LEVEL_FIELD: if (regByteEn[0]) lvl_nxt = regWdata[2:0];
                `ASR_OFS_IVEC: if (regByteEn[0]) vec_nxt = regWdata[7:0];
                default: ;
            endcase
        end
        if (regSel && !regWr) begin
            unique case (regAddr)
                `ASR_OFS_CHAN: rd_nxt = chan_r;
                `ASR_OFS_RATE: rd_nxt = {1'b0, rate_r};
                `ASR_OFS_IRQ_LEVEL_FIELD: rd_nxt = {`ASR_UPPER_ONES, 5'h00, lvl_r};
                `ASR_OFS_IVEC: rd_nxt = {`ASR_UPPER_ONES, vec_r};
                default:       rd_nxt = 16'h0000;
            endcase
        end
        ack_nxt   = intAckCycle ? vec_r : 8'h00;
        ackOe_nxt = intAckCycle && irqPending && (lvl_r != 3'h0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan_r  <= 16'h0000;
            rate_r  <= 15'h0000;
            lvl_r   <= 3'h0;
            vec_r   <= 8'h00;
            rd_r    <= 16'h0000;
            ack_r   <= 8'h00;
            ackOe_r <= 1'b0;
        end else begin
            chan_r  <= chan_nxt;
            rate_r  <= rate_nxt;
            lvl_r   <= lvl_nxt;
            vec_r   <= vec_nxt;
            rd_r    <= rd_nxt;
            ack_r   <= ack_nxt;
            ackOe_r <= ackOe_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign scan        = decode(chan_r);
    assign scanValid   = scan.valid;
    assign scanBig     = scan.big;
    assign scanBlock   = scan.block;
    assign scanFirst   = scan.first;
    assign scanTag     = chan_r[10:6];
    assign regRdata    = rd_r;
    assign ackData     = ack_r;
    assign ackDataOe   = ackOe_r;
    assign irqLevel    = lvl_r;
    assign irqEnabled  = (lvl_r != 3'h0);
    assign rif.divisor = rate_r;
    assign sampleTick  = rif.tick;

    asr_rate_gen u_rate (
        .clk   (clk),
        .rst_n (rst_n),
        .rif   (rif.gen)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_rate_bit15: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && !regWr && regAddr == `ASR_OFS_RATE) |=> !regRdata[15])
        else $error("rate bit 15 not zero");
    a_irq_level_field_ones: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && !regWr && regAddr == `ASR_OFS_IRQ_LEVEL_FIELD)
        |=> regRdata[15:3] == 13'h1FE0)
        else $error("level register upper bits wrong");
    a_ivec_read: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_IVEC && regByteEn[0])
        ##1 (regSel && !regWr && regAddr == `ASR_OFS_IVEC)
        |=> regRdata == {8'hFF, $past(regWdata[7:0], 2)})
        else $error("vector readback wrong");
    a_ack_vector: assert property (@(posedge clk) disable iff (!rst_n)
        intAckCycle |=> ackData == $past(vec_r))
        else $error("acknowledge byte not vector");
    a_soft_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (softReset && !(regSel && regWr)) |=> $stable(lvl_r) && $stable(vec_r))
        else $error("soft reset changed level or vector");
    a_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
        (lvl_r == 3'h0) |=> !ackDataOe)
        else $error("acknowledge with interrupts disabled");
    a_scan_single: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11011) |-> scanBig && scanBlock == 3'(ASR_BLK1)
        && scanFirst == chan_r[5:0])
        else $error("single channel decode wrong");
    a_scan_eight: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b10111) |-> !scanBig && scanFirst == {chan_r[2:0], 3'h0})
        else $error("eight block decode wrong");
    a_scan_wide: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11110) |-> scanFirst == {chan_r[2], 5'h00})
        else $error("thirty-two block decode wrong");

    // ----------------------------------------
    // decode, lane write, readback, acknowledge and tick checks
    // ----------------------------------------
    a_scan_one_small: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b10110) |-> !scanBig && scanBlock == 3'(ASR_BLK1)
        && scanFirst == chan_r[5:0])
        else $error("small single channel decode wrong");
    a_scan_none: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] < 5'b10110) |-> !scanValid)
        else $error("unmapped code taken as valid");
    a_scan_valid: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] >= 5'b10110) |-> scanValid)
        else $error("mapped code not valid");
    a_scan_eight_big: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11100) |-> scanBig && scanBlock == 3'(ASR_BLK8)
        && scanFirst == {chan_r[2:0], 3'h0})
        else $error("large eight block decode wrong");
    a_scan_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11000) |-> !scanBig && scanBlock == 3'(ASR_BLK16)
        && scanFirst == {chan_r[2:1], 4'h0})
        else $error("small sixteen block decode wrong");
    a_scan_sixteen_big: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11101) |-> scanBig && scanBlock == 3'(ASR_BLK16)
        && scanFirst == {chan_r[2:1], 4'h0})
        else $error("large sixteen block decode wrong");
    a_scan_half: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11001) |-> !scanBig && scanBlock == 3'(ASR_BLK32)
        && scanFirst == {chan_r[2], 5'h00})
        else $error("small thirty-two block decode wrong");
    a_scan_all: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11010) |-> !scanBig && scanBlock == 3'(ASR_BLK64)
        && scanFirst == 6'h00)
        else $error("small sixty-four decode wrong");
    a_scan_all_big: assert property (@(posedge clk) disable iff (!rst_n)
        (chan_r[15:11] == 5'b11111) |-> scanBig && scanBlock == 3'(ASR_BLK64)
        && scanFirst == 6'h00)
        else $error("large sixty-four decode wrong");
    a_scan_tag: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_CHAN && regByteEn == 2'b11)
        |=> scanTag == $past(regWdata[10:6]))
        else $error("tag bits not kept");
    a_rate_write: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_RATE && regByteEn == 2'b11)
        |=> rate_r == $past(regWdata[14:0]))
        else $error("rate word write lost");
    a_rate_lane: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_RATE && regByteEn == 2'b01)
        |=> rate_r[14:8] == $past(rate_r[14:8])
        && rate_r[7:0] == $past(regWdata[7:0]))
        else $error("rate byte write wrong");
    a_rate_read: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && !regWr && regAddr == `ASR_OFS_RATE)
        |=> regRdata[14:0] == $past(rate_r))
        else $error("rate readback wrong");
    a_lvl_write: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_IRQ_LEVEL_FIELD && regByteEn[0])
        |=> irqLevel == $past(regWdata[2:0]))
        else $error("level write lost");
    a_lvl_read: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && !regWr && regAddr == `ASR_OFS_IRQ_LEVEL_FIELD)
        |=> regRdata[2:0] == $past(lvl_r))
        else $error("level readback wrong");
    a_lvl_upper: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_IRQ_LEVEL_FIELD && !regByteEn[0])
        |=> $stable(lvl_r))
        else $error("upper byte write changed level");
    a_ivec_write: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_IVEC && regByteEn[0])
        |=> vec_r == $past(regWdata[7:0]))
        else $error("vector write lost");
    a_ivec_upper: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && regWr && regAddr == `ASR_OFS_IVEC && !regByteEn[0])
        |=> $stable(vec_r))
        else $error("upper byte write changed vector");
    a_ack_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !intAckCycle |=> ackData == 8'h00 && !ackDataOe)
        else $error("acknowledge byte outside cycle");
    a_ack_enable: assert property (@(posedge clk) disable iff (!rst_n)
        (intAckCycle && irqPending && lvl_r != 3'h0)
        |=> ackDataOe)
        else $error("acknowledge not answered");
    a_ack_pending: assert property (@(posedge clk) disable iff (!rst_n)
        !irqPending |=> !ackDataOe)
        else $error("acknowledge answered with nothing pending");
    a_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(regSel && !regWr) |=> $stable(regRdata))
        else $error("read data changed without read");
    a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (regSel && !regWr && !(regAddr inside {`ASR_OFS_CHAN, `ASR_OFS_RATE,
                                               `ASR_OFS_IRQ_LEVEL_FIELD, `ASR_OFS_IVEC}))
        |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_tick_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        sampleTick |=> !sampleTick)
        else $error("sample tick longer than one cycle");
endmodule
`default_nettype wire

// *** logic/asr_map.svh ***
// constants of the scan, rate and interrupt setup registers
// assumes a 16-bit register port with byte lanes, 100 MHz clock
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define ASR_OFS_CHAN  8'h04
`define ASR_OFS_RATE  8'h06
`define ASR_OFS_IRQ_LEVEL_FIELD  8'h08
`define ASR_OFS_IVEC  8'h0A
// ----------------------------------------
// fields and timing
// ----------------------------------------
`define ASR_RATE_KNEE  15'h007A
`define ASR_RATE_ADD   16'h0003
`define ASR_CLK_HZ     100000000
`define ASR_REF_HZ     12500000
`define ASR_FIX_HZ     100000
`define ASR_REF_DIV    (`ASR_CLK_HZ / `ASR_REF_HZ)
`define ASR_FIX_DIV    (`ASR_REF_HZ / `ASR_FIX_HZ)
`define ASR_UPPER_ONES 8'hFF
`endif

// *** logic/asr_pkg.sv ***
// types of the scan, rate and interrupt setup registers
// assumes nothing
`default_nettype none
package asr_pkg;
    typedef enum logic [2:0] {ASR_BLK1, ASR_BLK8, ASR_BLK16, ASR_BLK32, ASR_BLK64,
                              ASR_BLKNONE} asr_block_t;
    typedef struct packed {
        logic       valid;
        logic       big;
        asr_block_t block;
        logic [5:0] first;
    } asr_scan_t;
endpackage
`default_nettype wire

// *** logic/asr_rate_if.sv ***
// carries divisor to the rate generator and its tick back
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface asr_rate_if;
    logic [14:0] divisor;
    logic        tick;
    modport ctl (output divisor, input tick);
    modport gen (input divisor, output tick);
endinterface
`default_nettype wire

// *** logic/asr_rate_gen.sv ***
// sample tick generator from a 12.5 MHz enable
// assumes clk at 100 MHz, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module asr_rate_gen
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    asr_rate_if.gen  rif
);
    logic [2:0]  refCnt_r, refCnt_nxt;
    logic [15:0] smpCnt_r, smpCnt_nxt;
    logic        tick_r, tick_nxt;
    logic        refEn;
    logic [15:0] period;

    assign refEn = (refCnt_r == 3'(`ASR_REF_DIV - 1));
    always_comb begin
        if (rif.divisor <= `ASR_RATE_KNEE) begin
            period = 16'(`ASR_FIX_DIV);
        end else begin
            period = {1'b0, rif.divisor} + `ASR_RATE_ADD;
        end
        refCnt_nxt = refEn ? 3'h0 : refCnt_r + 3'h1;
        smpCnt_nxt = smpCnt_r;
        tick_nxt   = 1'b0;
        if (refEn) begin
            if (smpCnt_r >= period - 16'h0001) begin
                smpCnt_nxt = 16'h0000;
                tick_nxt   = 1'b1;
            end else begin
                smpCnt_nxt = smpCnt_r + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            refCnt_r <= 3'h0;
            smpCnt_r <= 16'h0000;
            tick_r   <= 1'b0;
        end else begin
            refCnt_r <= refCnt_nxt;
            smpCnt_r <= smpCnt_nxt;
            tick_r   <= tick_nxt;
        end
    end
    assign rif.tick = tick_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [18:0] gap_r, gap_nxt;     // clocks since the last tick
    logic        held_r, held_nxt;   // divisor steady since the last tick
    logic [14:0] seenDiv_r;

    always_comb begin
        gap_nxt  = tick_r ? 19'h0_0001 : gap_r + 19'h0_0001;
        held_nxt = tick_r || (held_r && rif.divisor == seenDiv_r);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_r     <= 19'h0_0000;
            held_r    <= 1'b0;
            seenDiv_r <= 15'h0000;
        end else begin
            gap_r     <= gap_nxt;
            held_r    <= held_nxt;
            seenDiv_r <= rif.divisor;
        end
    end

    a_fixed_rate: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_r && held_r && seenDiv_r <= `ASR_RATE_KNEE) |-> gap_r == 19'h0_03E8)
        else $error("fixed rate period wrong");
    a_var_rate: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_r && held_r && seenDiv_r > `ASR_RATE_KNEE)
        |-> gap_r == {({1'b0, seenDiv_r} + `ASR_RATE_ADD), 3'b000})
        else $error("divided rate period wrong");
endmodule
`default_nettype wire

// *** test/asr_host_model.sv ***
// host interrupt handler model: raises a request, runs one acknowledge
// assumes the device answers the acknowledge one cycle later
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       raise,
    input  wire logic       irqEnabled,
    input  wire logic       ackDataOe,
    input  wire logic [7:0] ackData,
    output logic            irqPending,
    output logic            intAckCycle,
    output logic      [7:0] gotVector,
    output logic            gotValid
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqPending  <= 1'b0;
            intAckCycle <= 1'b0;
            gotVector   <= 8'h00;
            gotValid    <= 1'b0;
        end else begin
            irqPending  <= raise;
            // one acknowledge per new request
            intAckCycle <= raise & ~irqPending & irqEnabled;
            gotValid    <= ackDataOe;
            if (ackDataOe) begin
                gotVector <= ackData;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// register, scan decode, rate and acknowledge tests
// assumes the register bank and the host model
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module testbench
    import asr_pkg::*;
;
    logic clk, rst_n, regSel, regWr, softReset, raise;
    logic [7:0] regAddr;
    logic [1:0] regByteEn;
    logic [15:0] regWdata, regRdata;
    logic intAckCycle, ackDataOe, irqPending, irqEnabled, scanValid, scanBig, sampleTick;
    logic gotValid;
    logic [7:0] ackData, gotVector;
    logic [2:0] irqLevel, scanBlock;
    logic [5:0] scanFirst;
    logic [4:0] scanTag;
    int failures = 0;
    int nCompared = 0;
    always #5 clk = ~clk;
    asr_scan_rate_irq_regs i_dut (.clk(clk), .rst_n(rst_n), .regSel(regSel), .regWr(regWr),
        .regAddr(regAddr), .regByteEn(regByteEn), .regWdata(regWdata), .regRdata(regRdata),
        .softReset(softReset), .intAckCycle(intAckCycle), .ackData(ackData),
        .ackDataOe(ackDataOe), .irqPending(irqPending), .irqLevel(irqLevel),
        .irqEnabled(irqEnabled), .scanValid(scanValid), .scanBig(scanBig),
        .scanBlock(scanBlock), .scanFirst(scanFirst), .scanTag(scanTag),
        .sampleTick(sampleTick));
    asr_host_model i_host (.clk(clk), .rst_n(rst_n), .raise(raise), .irqEnabled(irqEnabled),
        .ackDataOe(ackDataOe), .ackData(ackData), .irqPending(irqPending),
        .intAckCycle(intAckCycle), .gotVector(gotVector), .gotValid(gotValid));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic close_out();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        regSel <= 1'b1;
        regWr <= 1'b1;
        regAddr <= a;
        regByteEn <= be;
        regWdata <= d;
        @(posedge clk);
        regSel <= 1'b0;
        regWr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        regSel <= 1'b1;
        regWr <= 1'b0;
        regAddr <= a;
        @(posedge clk);
        regSel <= 1'b0;
        #1 check(what, exp, regRdata);
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sampleTick !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            failures++;
            close_out();
        end
    endtask
    task automatic measure(input logic [15:0] div, input logic [15:0] period);
        int n;
        reg_wr(`ASR_OFS_RATE, div, 2'b11);
        repeat (3) wait_tick(n);
        check("rate period", period, 16'(n));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [5:0] low, first;
        logic [2:0] blk;
        clk = 0;
        rst_n = 0;
        {regSel, regWr, softReset, raise, regAddr, regByteEn, regWdata} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(`ASR_OFS_RATE, 16'h0000, "rate reset");
        reg_rd(`ASR_OFS_IRQ_LEVEL_FIELD, 16'hff00, "level reset");
        reg_rd(`ASR_OFS_IVEC, 16'hff00, "vector reset");
        check("scan valid", 16'h0000, 16'(scanValid));
        $display("test reset done");
        reg_wr(`ASR_OFS_RATE, 16'hffff, 2'b11);
        reg_rd(`ASR_OFS_RATE, 16'h7fff, "rate bit 15");
        for (int i = 0; i < 8; i++) begin
            reg_wr(`ASR_OFS_IRQ_LEVEL_FIELD, 16'(i), 2'b01);
            check("level", 16'(i), {13'h0000, irqLevel});
            check("enable", 16'(i != 0), 16'(irqEnabled));
        end
        reg_wr(`ASR_OFS_IRQ_LEVEL_FIELD, 16'h00fd, 2'b01);
        reg_wr(`ASR_OFS_IRQ_LEVEL_FIELD, 16'h0002, 2'b10);
        reg_rd(`ASR_OFS_IRQ_LEVEL_FIELD, 16'hff05, "level bits");
        reg_wr(`ASR_OFS_IVEC, 16'h125a, 2'b01);
        reg_rd(`ASR_OFS_IVEC, 16'hff5a, "vector");
        reg_rd(8'h1e, 16'h0000, "unmapped");
        @(posedge clk) softReset <= 1'b1;
        @(posedge clk) softReset <= 1'b0;
        reg_rd(`ASR_OFS_IRQ_LEVEL_FIELD, 16'hff05, "level soft reset");
        reg_rd(`ASR_OFS_IVEC, 16'hff5a, "vector soft reset");
        @(posedge clk) raise <= 1'b1;
        for (int i = 0; i < 10 && gotValid !== 1'b1; i++) @(posedge clk) #1;
        if (gotValid !== 1'b1) begin
            failures++;
            close_out();
        end
        check("ack vector", 16'h015a, {7'h00, gotValid, gotVector});
        raise <= 1'b0;
        $display("test registers done");
        for (int c = 22; c < 32; c++) begin
            low = 6'(c * 11 + 5);
            first = 6'h00;
            blk = ASR_BLK64;
            case (c)
                22, 27: begin blk = ASR_BLK1; first = low; end
                23, 28: begin blk = ASR_BLK8; first = {low[2:0], 3'h0}; end
                24, 29: begin blk = ASR_BLK16; first = {low[2:1], 4'h0}; end
                25, 30: begin blk = ASR_BLK32; first = {low[2], 5'h00}; end
                default: ;
            endcase
            reg_wr(`ASR_OFS_CHAN, {5'(c), 5'(c + 3), low}, 2'b11);
            check("scan decode", {1'b1, 1'(c > 26), blk, first, 5'(c + 3)},
                  {scanValid, scanBig, scanBlock, scanFirst, scanTag});
        end
        $display("test scan done");
        measure(16'h0000, 16'h03e8);
        measure(16'h007a, 16'h03e8);
        measure(16'h007b, 16'h03f0);
        measure(16'h0080, 16'h0418);
        $display("test rate done");
        close_out();
    end
endmodule
`default_nettype wire
